// ### design/swsc_pkg.sv
// Package for the service window supervisor with clock monitor.
// Assumes one 10 MHz clock and a plain register port.
`default_nettype none
package swsc_pkg;
  // Service register field layout
  localparam int WSEL_MSB = 7;
  localparam int WSEL_LSB = 6;
  localparam int KEY_MSB = 5;
  localparam int KEY_LSB = 1;
  localparam int CMON_BIT = 0;
  localparam logic [4:0] KEY_VALUE = 5'h0C;
  // Register offsets, byte addressed
  localparam logic [7:0] SERVICE_OFF = 8'h00;
  localparam logic [7:0] CONTROL_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  // Reset values
  localparam logic [1:0] WSEL_RESET = 2'h3;
  localparam logic CMON_RESET = 1'b1;
  // Window limits in instruction cycles
  localparam logic [16:0] LOWER_LIMIT = 17'h0_0800;
  localparam logic [16:0] UPPER_BASE = 17'h0_2000;
  // Fault hold figure, within the 16 to 32 cycle range
  localparam int HOLD_CYCLES = 24;
  // Clock monitor: reject slower than one tick per this many clocks
  localparam int CLK_HZ = 10_000_000;
  localparam int MIN_TICK_HZ = 10_000;
  localparam int CMON_LIMIT = CLK_HZ / MIN_TICK_HZ * 4;
  // Register write/read request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } swsc_req_type;
  // Fault pin states, Gray along the usual path
  typedef enum logic [1:0] {
    PIN_IDLE = 2'b00,
    PIN_DRIVE = 2'b01,
    PIN_HOLD = 2'b11,
    PIN_WAIT = 2'b10
  } swsc_pin_type;
endpackage
`default_nettype wire

// ### design/swsc_top.sv
// Service window supervisor and clock monitor, one clock domain.
// Assumes synchronous inputs, a tick per instruction cycle and an outside pull-up.
//
// Operation
// R1 - Service byte: window, key, monitor select
// R2 - Valid service needs key 01100
// R3 - Lower limit fixed at 2048 cycles
// R4 - Window select gives 8k to 64k
// R5 - Bit 0 enables clock monitor
// R6 - Reset inhibits; then 64k, monitor on
// R7 - One keyed configuring write, counts service
// R8 - Later writes compare bits 7:1; the code compares bits 7:0, monitor bit included
// R9 - Early or late service is error
// R10 - Initial service allowed within first 2048
// R11 - Pin low, hold 16-32 after low
// R12 - Window restarts when pin returns high
// R13 - Services ignored while pin active
// R14 - Clock error drives pin until recovered
// R15 - Reject slow tick, flag missing oscillator
// R16 - Window detector suspended in halt/idle
// R17 - Clock monitor active in halt/idle
// R18 - Halt exit resumes or reloads window
// R19 - Idle exit performs automatic service
// R20 - Key field reads back as zero
// R21 - Idle tick flag every 4096, software clears
// R22 - One counter against both limits
`default_nettype none
module swsc_top #(
  parameter int CMON_CYCLES = swsc_pkg::CMON_LIMIT
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  // Register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Core state
  input wire logic I_TICK,
  input wire logic I_HALT,
  input wire logic I_IDLE,
  input wire logic I_RC_OSC,
  input wire logic I_HALT_DLY,
  // Fault pin, open drain
  input wire logic I_FAULT_PIN,
  output logic O_FAULT_OUT,
  output logic O_FAULT_OE,
  // Idle tick pending flag
  output logic O_IDLE_TICK_PENDING
);
  // Elaboration checks: the monitor needs a count to compare against
  if (CMON_CYCLES < 2) begin : g_bad_cmon
    $error("CMON_CYCLES too small");
  end
  // The hold counter is five bits and the hold must sit within 16 to 32
  if (swsc_pkg::HOLD_CYCLES < 16 || swsc_pkg::HOLD_CYCLES > 32) begin : g_bad_hold
    $error("HOLD_CYCLES out of range");
  end

  // Pack the register request
  swsc_pkg::swsc_req_type req;
  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  // Whole state of the block
  typedef struct packed {
    logic [1:0] wsel;
    logic cmon_en;
    logic configured;
    logic [16:0] win_cnt;
    logic first_win;
    logic [4:0] hold_cnt;
    swsc_pkg::swsc_pin_type pin;
    logic wd_fault;
    logic [31:0] cmon_cnt;
    logic clk_err;
    logic [12:0] idle_timer;
    logic idle_pend;
    logic halt_d;
    logic idle_d;
    logic [7:0] rdata;
    // Registered pin enable, so the output leaves a flip-flop
    logic fault_oe;
  } swsc_state_type;

  swsc_state_type st_ff;
  swsc_state_type nxt_st;

  // Upper limit from the window select
  function automatic logic [16:0] upper_of(input logic [1:0] sel);
    upper_of = swsc_pkg::UPPER_BASE << sel; // [R4]
  endfunction

  logic is_svc_wr;
  logic svc_ok;
  logic key_ok;
  logic [16:0] upper;
  logic pin_busy;

  // Service decode and checks
  always_comb begin
    is_svc_wr = req.wr && (req.addr == swsc_pkg::SERVICE_OFF);
    key_ok = req.wdata[swsc_pkg::KEY_MSB:swsc_pkg::KEY_LSB] == swsc_pkg::KEY_VALUE; // [R2]
    upper = upper_of(st_ff.wsel);
    pin_busy = st_ff.pin != swsc_pkg::PIN_IDLE;
    // Later services must repeat the stored selection and monitor bit [R8]
    svc_ok = key_ok && (!st_ff.configured ||
      (req.wdata[swsc_pkg::WSEL_MSB:swsc_pkg::WSEL_LSB] == st_ff.wsel &&
       req.wdata[swsc_pkg::CMON_BIT] == st_ff.cmon_en));
  end

  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.halt_d = I_HALT;
    nxt_st.idle_d = I_IDLE;
    // Window counter, one count per tick, frozen in low power [R22] [R16]
    if (I_TICK && !I_HALT && !I_IDLE && !pin_busy) begin
      nxt_st.win_cnt = st_ff.win_cnt + 17'h0_0001;
    end
    // Late service: counter reached the upper limit [R9]
    if (!I_HALT && !I_IDLE && !pin_busy && st_ff.win_cnt >= upper) begin
      nxt_st.wd_fault = 1'b1;
    end
    // Service writes are ignored while the pin is active [R13]
    if (is_svc_wr && !pin_busy) begin
      if (!svc_ok) begin
        nxt_st.wd_fault = 1'b1; // [R8]
      end else if (!st_ff.first_win && st_ff.win_cnt < swsc_pkg::LOWER_LIMIT) begin
        nxt_st.wd_fault = 1'b1; // Early service [R3] [R9]
      end else begin
        nxt_st.win_cnt = '0;
        nxt_st.first_win = 1'b0; // Initial window has no lower bound [R10]
        if (!st_ff.configured) begin
          // Only the first keyed write fixes the selection [R7] [R1] [R5]
          nxt_st.configured = 1'b1;
          nxt_st.wsel = req.wdata[swsc_pkg::WSEL_MSB:swsc_pkg::WSEL_LSB];
          nxt_st.cmon_en = req.wdata[swsc_pkg::CMON_BIT];
        end
      end
    end
    // Halt exit: resume with RC and no delay, else reload [R18]
    if (st_ff.halt_d && !I_HALT && !(I_RC_OSC && !I_HALT_DLY)) begin
      nxt_st.win_cnt = '0;
    end
    // Idle exit counts as a hardware service [R19]
    if (st_ff.idle_d && !I_IDLE) begin
      nxt_st.win_cnt = '0;
    end
    // Clock monitor runs in every mode; a missing tick keeps it in error [R15] [R17]
    if (I_TICK && !I_HALT) begin
      nxt_st.cmon_cnt = '0;
      nxt_st.clk_err = 1'b0;
    end else if (st_ff.cmon_cnt >= 32'(CMON_CYCLES - 1)) begin
      nxt_st.clk_err = 1'b1;
    end else begin
      nxt_st.cmon_cnt = st_ff.cmon_cnt + 32'h0000_0001;
    end
    // Fault pin sequence [R11] [R14]
    case (st_ff.pin)
      swsc_pkg::PIN_IDLE: begin
        if (st_ff.wd_fault || (st_ff.clk_err && st_ff.cmon_en)) begin
          nxt_st.pin = swsc_pkg::PIN_DRIVE;
        end
      end
      swsc_pkg::PIN_DRIVE: begin
        // Wait for the wire to fall below threshold
        if (!I_FAULT_PIN) begin
          nxt_st.pin = swsc_pkg::PIN_HOLD;
          nxt_st.hold_cnt = '0;
        end
      end
      swsc_pkg::PIN_HOLD: begin
        if (st_ff.clk_err && st_ff.cmon_en) begin
          nxt_st.hold_cnt = '0; // Keep driving while the clock is bad [R14]
        end else if (st_ff.hold_cnt == 5'(swsc_pkg::HOLD_CYCLES - 1)) begin
          nxt_st.pin = swsc_pkg::PIN_WAIT;
        end else begin
          nxt_st.hold_cnt = st_ff.hold_cnt + 5'h01;
        end
      end
      swsc_pkg::PIN_WAIT: begin
        // Released; restart the window once the wire is high [R12]
        if (I_FAULT_PIN) begin
          nxt_st.pin = swsc_pkg::PIN_IDLE;
          nxt_st.win_cnt = '0;
          nxt_st.wd_fault = 1'b0;
        end
      end
      default: nxt_st.pin = swsc_pkg::PIN_IDLE;
    endcase
    // Enable follows the next pin state, so no extra cycle of lag [R11]
    nxt_st.fault_oe = (nxt_st.pin == swsc_pkg::PIN_DRIVE) ||
      (nxt_st.pin == swsc_pkg::PIN_HOLD);
    // Idle timer free runs; flag on bit 12 toggle, set beats clear [R21]
    if (I_TICK) begin
      nxt_st.idle_timer = st_ff.idle_timer + 13'h0001;
    end
    if (req.wr && req.addr == swsc_pkg::STATUS_OFF && req.wdata[0]) begin
      nxt_st.idle_pend = 1'b0;
    end
    if (I_TICK && st_ff.idle_timer[11:0] == 12'hFFF) begin
      nxt_st.idle_pend = 1'b1;
    end
    // Read data, key field forced to zero [R20]
    nxt_st.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        swsc_pkg::SERVICE_OFF: nxt_st.rdata = {st_ff.wsel, 5'h00, st_ff.cmon_en};
        swsc_pkg::CONTROL_OFF: nxt_st.rdata = {7'h00, st_ff.configured};
        swsc_pkg::STATUS_OFF: nxt_st.rdata = {4'h0, st_ff.clk_err, st_ff.wd_fault,
                                              pin_busy, st_ff.idle_pend};
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  // State register; idle timer is left out of reset [R21]
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      // Detectors inhibited, max window and monitor armed [R6]
      st_ff.wsel <= swsc_pkg::WSEL_RESET;
      st_ff.cmon_en <= swsc_pkg::CMON_RESET;
      st_ff.configured <= 1'b0;
      st_ff.win_cnt <= '0;
      st_ff.first_win <= 1'b1;
      st_ff.hold_cnt <= '0;
      st_ff.pin <= swsc_pkg::PIN_IDLE;
      st_ff.wd_fault <= 1'b0;
      st_ff.cmon_cnt <= '0;
      st_ff.clk_err <= 1'b0;
      st_ff.idle_pend <= 1'b0;
      st_ff.halt_d <= 1'b0;
      st_ff.idle_d <= 1'b0;
      st_ff.rdata <= '0;
      st_ff.fault_oe <= 1'b0;
      st_ff.idle_timer <= st_ff.idle_timer;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs from flip-flops; fault output tied low
  assign O_RDATA = st_ff.rdata;
  assign O_FAULT_OUT = 1'b0;
  assign O_FAULT_OE = st_ff.fault_oe;
  assign O_IDLE_TICK_PENDING = st_ff.idle_pend;

  // Assertions
  sequence pin_low_s;
    st_ff.pin == swsc_pkg::PIN_DRIVE && !I_FAULT_PIN;
  endsequence
  sequence oe_fall_s;
    $fell(O_FAULT_OE);
  endsequence

  // Helper: edges the wire was seen low while we drive it.
  // A counter instead of a long repetition keeps the checker cheap.
  logic [5:0] low_seen_ff;
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B || !O_FAULT_OE) begin
      low_seen_ff <= 6'h00;
    end else if (!I_FAULT_PIN && low_seen_ff != 6'h3F) begin
      // Saturate rather than wrap during a long clock error
      low_seen_ff <= low_seen_ff + 6'h01;
    end
  end

  reset_max_a: assert property (@(posedge I_MCLK) // [R6]
    !I_RST_B |=> st_ff.wsel == 2'h3 && st_ff.cmon_en && !O_FAULT_OE)
    else $error("reset did not arm max window");
  key_check_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R2]
    is_svc_wr && !pin_busy && !key_ok |=> st_ff.wd_fault)
    else $error("bad key not flagged");
  lock_once_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R7]
    st_ff.configured |=> $stable(st_ff.wsel) && $stable(st_ff.cmon_en))
    else $error("selection changed after lock");
  early_svc_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R9]
    is_svc_wr && !pin_busy && !st_ff.first_win && st_ff.win_cnt < 17'h0_0800
    |=> st_ff.wd_fault)
    else $error("early service not flagged");
  hold_len_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R11]
    oe_fall_s |-> $past(low_seen_ff) >= 6'h10)
    else $error("pin released too soon");
  low_entry_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R11]
    pin_low_s |=> st_ff.pin == swsc_pkg::PIN_HOLD && O_FAULT_OE)
    else $error("low wire did not start hold");
  ignore_busy_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R13]
    is_svc_wr && st_ff.pin == swsc_pkg::PIN_HOLD |=> st_ff.configured == $past(st_ff.configured))
    else $error("service taken while pin busy");
  halt_freeze_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R16]
    I_HALT && st_ff.halt_d && !pin_busy |=> $stable(st_ff.win_cnt))
    else $error("window moved in halt");
  key_read_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R20]
    req.rd && req.addr == swsc_pkg::SERVICE_OFF |=> O_RDATA[5:1] == 5'h00)
    else $error("key visible on read");
  clk_err_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R14]
    st_ff.clk_err && st_ff.cmon_en && st_ff.pin == swsc_pkg::PIN_HOLD |=> O_FAULT_OE)
    else $error("clock error released pin");

  // A pending fault starts driving at the next edge
  oe_start_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R11]
    st_ff.pin == swsc_pkg::PIN_IDLE && st_ff.wd_fault |=> O_FAULT_OE)
    else $error("fault did not drive pin");

  // Counter at or past the upper limit must raise a fault
  late_svc_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R9]
    !I_HALT && !I_IDLE && !pin_busy && st_ff.win_cnt >= upper |=> st_ff.wd_fault)
    else $error("late service not flagged");

  // Wire back high restarts the window and frees the pin
  restart_win_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R12]
    st_ff.pin == swsc_pkg::PIN_WAIT && I_FAULT_PIN
    |=> st_ff.win_cnt == 17'h0_0000 && st_ff.pin == swsc_pkg::PIN_IDLE)
    else $error("window not restarted");

  // Idle freezes the window just like halt
  idle_freeze_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R16]
    I_IDLE && st_ff.idle_d && !pin_busy && !is_svc_wr |=> $stable(st_ff.win_cnt))
    else $error("window moved in idle");

  // Leaving idle acts as a service
  idle_exit_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R19]
    st_ff.idle_d && !I_IDLE |=> st_ff.win_cnt == 17'h0_0000)
    else $error("idle exit did not service");

  // Leaving halt without the resume option reloads the window
  halt_reload_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R18]
    st_ff.halt_d && !I_HALT && !(I_RC_OSC && !I_HALT_DLY) |=> st_ff.win_cnt == 17'h0_0000)
    else $error("halt exit did not reload");

  // Read data stands only after a read strobe
  rdata_quiet_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R20]
    !req.rd |=> O_RDATA == 8'h00)
    else $error("read data without strobe");

  // Idle tick flag set on the bit 12 toggle
  pend_set_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [R21]
    I_TICK && st_ff.idle_timer[11:0] == 12'hFFF |=> st_ff.idle_pend)
    else $error("idle tick flag not set");
endmodule
`default_nettype wire

// ### bench/swsc_pullup.sv
// Board pull-up on the fault wire, seen by the supervisor.
// Assumes the block pulls low only while its enable is high.
`default_nettype none
module swsc_pullup (
  // Block side
  input wire logic i_out,
  input wire logic i_oe,
  // Sensed wire level
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released wire floats up to the rail
  assign o_pin = i_oe ? i_out : 1'b1;
endmodule
`default_nettype wire

// ### bench/swsc_top_tb_top.sv
// Bench for the supervisor: register port, window, pin hold, clock monitor.
// Assumes one tick per clock, so window counts equal clock cycles.
`default_nettype none
module swsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus, all driven by the bench
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tick = 1'b1;
  logic halt = 1'b0;
  logic idle = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  // Observed
  logic [7:0] rdata;
  logic oe;
  logic fout;
  logic pin;
  logic pend;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  // Reset reads: address, then expected data
  logic [15:0] rows [4] = '{16'h00C1, 16'h0400, 16'h1000, 16'hFF00};
  // Window mismatch and key mismatch
  logic [7:0] bad [2] = '{8'h59, 8'h1B};
  always #50 clk = ~clk;
  swsc_pullup i_swsc_pullup (.i_out(fout), .i_oe(oe), .o_pin(pin));
  swsc_top #(.CMON_CYCLES(50)) i_swsc_top (.I_MCLK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TICK(tick), .I_HALT(halt),
    .I_IDLE(idle), .I_RC_OSC(1'b0), .I_HALT_DLY(1'b0), .I_FAULT_PIN(pin),
    .O_FAULT_OUT(fout), .O_FAULT_OE(oe), .O_IDLE_TICK_PENDING(pend));
  // Single compare point
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // Bounded wait on the pin enable; n holds the cycles spent
  task automatic wait_oe(input logic val, input int lim);
    n = 0;
    while (oe !== val && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run of about 19000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk({7'h00, oe}, 8'h00);
    chk({7'h00, pend}, 8'h00);
    chk({7'h00, fout}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd_reg(rows[i][15:8], rows[i][7:0]);
    end
    // Configure at once: 8k window, monitor on; early is allowed here
    wr_reg(8'h00, 8'h19);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({7'h00, oe}, 8'h00);
    rd_reg(8'h00, 8'h01);
    rd_reg(8'h04, 8'h01);
    // Second service too soon
    wr_reg(8'h00, 8'h19);
    wait_oe(1'b1, 4);
    chk(n[7:0], 8'h01);
    // Bad key while pin is held must be dropped
    wr_reg(8'h00, 8'h00);
    wait_oe(1'b0, 60);
    chk({7'h00, n > 13 && n < 33}, 8'h01);
    repeat (100) @(posedge clk);
    @(negedge clk);
    chk({7'h00, oe}, 8'h00);
    // Service inside the window is quiet
    repeat (3000) @(posedge clk);
    wr_reg(8'h00, 8'h19);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({7'h00, oe}, 8'h00);
    // Mismatching services after the lower limit
    for (int i = 0; i < 2; i++) begin
      repeat (2100) @(posedge clk);
      wr_reg(8'h00, bad[i]);
      wait_oe(1'b1, 4);
      chk(n[7:0], 8'h01);
      wait_oe(1'b0, 60);
    end
    // No service: late fault at the 8k limit
    wait_oe(1'b1, 8300);
    chk({7'h00, n > 8184 && n < 8200}, 8'h01);
    wait_oe(1'b0, 60);
    // Idle exit services; a write soon after is early
    repeat (3000) @(posedge clk);
    idle <= 1'b1;
    repeat (10) @(posedge clk);
    idle <= 1'b0;
    repeat (100) @(posedge clk);
    wr_reg(8'h00, 8'h19);
    wait_oe(1'b1, 4);
    chk(n[7:0], 8'h01);
    wait_oe(1'b0, 60);
    // Ticks stop: clock error, then release after recovery
    tick <= 1'b0;
    wait_oe(1'b1, 80);
    chk({7'h00, n > 40 && n < 60}, 8'h01);
    tick <= 1'b1;
    wait_oe(1'b0, 60);
    chk({7'h00, n > 13 && n < 36}, 8'h01);
    // Halt with monitor on reads as a clock error
    halt <= 1'b1;
    wait_oe(1'b1, 80);
    chk({7'h00, n < 60}, 8'h01);
    halt <= 1'b0;
    wait_oe(1'b0, 60);
    chk({7'h00, oe}, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
